/* File: hdl/rtp_fifo.sv */
// Two-entry trace word FIFO
module rtp_fifo (
   input  wire logic               clk_sys,
   input  wire logic               reset,
   input  wire logic               wrValid,
   input  rtp_pkg::rtp_entry_t     wrEntry,
   output logic                    wrReady,
   output logic                    rdValid,
   output rtp_pkg::rtp_entry_t     rdEntry,
   input  wire logic               rdReady
);

   // ------------------------------------------------------------
   // Storage and pointers
   // ------------------------------------------------------------
   rtp_pkg::rtp_entry_t mem_r [rtp_pkg::FIFO_DEPTH];
   logic                wrPtr_r;
   logic                rdPtr_r;
   logic [1:0]          count_r;
   logic                doWr;
   logic                doRd;

   assign wrReady = (count_r != 2'(rtp_pkg::FIFO_DEPTH));
   assign rdValid = (count_r != 2'h0);
   assign rdEntry = mem_r[rdPtr_r];
   assign doWr    = wrValid & wrReady;
   assign doRd    = rdValid & rdReady;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wrPtr_r <= 1'b0;
         rdPtr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (doWr) begin
            mem_r[wrPtr_r] <= wrEntry;
            wrPtr_r        <= ~wrPtr_r;
         end
         if (doRd) begin
            rdPtr_r <= ~rdPtr_r;
         end
         count_r <= count_r + 2'(doWr) - 2'(doRd);
      end
   end

endmodule

/* File: hdl/rtp_pkg.sv */
// Package of constants and carrier types for the real-time trace port
// Function
// - Port has a 4-bit status nibble and a 4-bit trace data nibble.
// - Status nibble is registered on clk_sys; may lead or lag bus activity.
// - Codes 0 continue, 1 begin, 3 user entry, 5 taken branch, 7 exception return.
// - Codes 8 to B announce a 1- to 4-byte transfer on data nibble.
// - Codes C exception, D emulator entry, E stopped, F halted.
// - Codes C to F are held while the mode or operation lasts.
// - All other codes are refreshed every machine cycle.
// - Status marks the first address-generate/execute cycle of each instruction.
// - Register-based branch gives 5, then optional count marker, then target nibbles.
// - Target address byte count is configurable as 2, 3 or 4.
// - Pending trace data sits in a two-entry 32-bit FIFO.
// - FIFO takes branch targets and selected operand data for later output.
// - Core stall is registered: it rises one cycle after both FIFO entries are full and drops one cycle after an entry frees.
// - Count code appears one cycle before the first data nibble when no core event or write-trace takes that status cycle.
// - Data shifts out one nibble per clock, least significant nibble first.
// - Trigger-marker instruction shows code 4.
// - Write-trace-data operand goes to data nibble always, also showing code 4; the code drops it when both FIFO entries are full.
// - Any halt shows the halted code on the status nibble.
package rtp_pkg;

   // ------------------------------------------------------------
   // Status codes
   // ------------------------------------------------------------
   localparam logic [3:0] PST_CONTINUE  = 4'h0;
   localparam logic [3:0] PST_BEGIN     = 4'h1;
   localparam logic [3:0] PST_USER      = 4'h3;
   localparam logic [3:0] PST_MARKER    = 4'h4;
   localparam logic [3:0] PST_BRANCH    = 4'h5;
   localparam logic [3:0] PST_EXC_RET   = 4'h7;
   localparam logic [3:0] PST_XFER_BASE = 4'h8;
   localparam logic [3:0] PST_EXCEPTION = 4'hC;
   localparam logic [3:0] PST_EMULATOR  = 4'hD;
   localparam logic [3:0] PST_STOPPED   = 4'hE;
   localparam logic [3:0] PST_HALTED    = 4'hF;

   // ------------------------------------------------------------
   // Data path constants
   // ------------------------------------------------------------
   localparam int         FIFO_DEPTH  = 2;
   localparam int         WORD_W      = 32;
   localparam logic [3:0] DATA_IDLE   = 4'h0;
   localparam logic [2:0] NIB_PER_BYTE = 3'h2;

   // Target address size selection
   localparam logic [1:0] TGT_2BYTE = 2'h1;
   localparam logic [1:0] TGT_3BYTE = 2'h2;
   localparam logic [1:0] TGT_4BYTE = 2'h3;

   // Operand size of a captured word
   typedef enum logic [1:0] {
      RTP_SZ_1 = 2'h0,
      RTP_SZ_2 = 2'h1,
      RTP_SZ_3 = 2'h2,
      RTP_SZ_4 = 2'h3
   } rtp_size_t;

   // Per-cycle core event report
   typedef struct packed {
      logic instrBegin;
      logic userEntry;
      logic branchTaken;
      logic excReturn;
      logic marker;
      logic exception;
      logic emulator;
      logic stopped;
      logic halted;
   } rtp_core_evt_t;

   // Captured trace word
   typedef struct packed {
      logic [31:0] data;
      rtp_size_t   size;
   } rtp_entry_t;

endpackage

/* File: hdl/rtp_shifter.sv */
// Nibble serialiser for trace words
module rtp_shifter (
   input  wire logic               clk_sys,
   input  wire logic               reset,
   input  wire logic               inValid,
   input  rtp_pkg::rtp_entry_t     inEntry,
   output logic                    inReady,
   output logic                    announce,
   output logic [3:0]              announceCode,
   output logic [3:0]              dataNibble
);

   // ------------------------------------------------------------
   // Shift state
   // ------------------------------------------------------------
   logic [31:0] shift_r;
   logic [31:0] shift_nxt;
   logic [3:0]  left_r;
   logic [3:0]  left_nxt;
   logic [3:0]  data_r;
   logic [3:0]  data_nxt;
   logic        load;
   logic [3:0]  nibCount;

   // Next word is loaded in the last nibble cycle so words follow back to back
   assign load         = inValid & (left_r <= 4'h1);
   assign inReady      = load;
   assign announce     = load;
   assign announceCode = rtp_pkg::PST_XFER_BASE | {2'h0, inEntry.size};
   assign nibCount     = 4'({inEntry.size, 1'b0}) + 4'(rtp_pkg::NIB_PER_BYTE);
   assign shift_nxt    = load ? inEntry.data : {4'h0, shift_r[31:4]};
   assign left_nxt     = load ? nibCount : ((left_r != 4'h0) ? left_r - 4'h1 : 4'h0);
   assign data_nxt     = (left_r != 4'h0) ? shift_r[3:0] : rtp_pkg::DATA_IDLE;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         shift_r <= 32'h0;
         left_r  <= 4'h0;
         data_r  <= rtp_pkg::DATA_IDLE;
      end else begin
         shift_r <= shift_nxt;
         left_r  <= left_nxt;
         data_r  <= data_nxt;
      end
   end

   assign dataNibble = data_r;

endmodule

/* File: hdl/rtp_trace_port.sv */
// Real-time trace port top: status encoder, capture and data nibble output
module rtp_trace_port (
   input  wire logic               clk_sys,
   input  wire logic               reset,
   input  rtp_pkg::rtp_core_evt_t  coreEvt,
   input  wire logic               branchVariant,
   input  wire logic [31:0]        branchTarget,
   input  wire logic [1:0]         targetSize,
   input  wire logic               operandValid,
   input  wire logic [31:0]        operandData,
   input  rtp_pkg::rtp_size_t      operandSize,
   input  wire logic               writeTraceValid,
   input  wire logic [31:0]        writeTraceData,
   input  rtp_pkg::rtp_size_t      writeTraceSize,
   output logic                    coreStall,
   output logic [3:0]              core_status_nibble,
   output logic [3:0]              trace_data_nibble
);

   // ------------------------------------------------------------
   // Capture selection
   // ------------------------------------------------------------
   rtp_pkg::rtp_entry_t capEntry;
   rtp_pkg::rtp_entry_t outEntry;
   logic                capValid;
   logic                fifoReady;
   logic                outValid;
   logic                outReady;
   logic                announce;
   logic [3:0]          announceCode;
   logic                varBranch;
   rtp_pkg::rtp_size_t  tgtSize;

   // Target size of 2, 3 or 4 bytes; an out-of-range setting means 4
   assign tgtSize = (targetSize == rtp_pkg::TGT_2BYTE) ? rtp_pkg::RTP_SZ_2 :
                    (targetSize == rtp_pkg::TGT_3BYTE) ? rtp_pkg::RTP_SZ_3 :
                    rtp_pkg::RTP_SZ_4;

   // Write-trace-data has priority over branch target and operand
   assign varBranch = coreEvt.branchTaken & branchVariant;
   assign capValid  = writeTraceValid | varBranch | operandValid;
   assign capEntry  = writeTraceValid ? rtp_pkg::rtp_entry_t'{data: writeTraceData, size: writeTraceSize} :
                      varBranch       ? rtp_pkg::rtp_entry_t'{data: branchTarget, size: tgtSize} :
                      rtp_pkg::rtp_entry_t'{data: operandData, size: operandSize};

   rtp_fifo u_fifo (
      .clk_sys (clk_sys),
      .reset   (reset),
      .wrValid (capValid),
      .wrEntry (capEntry),
      .wrReady (fifoReady),
      .rdValid (outValid),
      .rdEntry (outEntry),
      .rdReady (outReady)
   );

   rtp_shifter u_shift (
      .clk_sys      (clk_sys),
      .reset        (reset),
      .inValid      (outValid),
      .inEntry      (outEntry),
      .inReady      (outReady),
      .announce     (announce),
      .announceCode (announceCode),
      .dataNibble   (trace_data_nibble)
   );

   // ------------------------------------------------------------
   // Status encoder
   // ------------------------------------------------------------
   logic [3:0] status_r;
   logic [3:0] status_nxt;
   logic       stall_r;

   // Multicycle codes follow their level inputs, so they hold while the mode lasts
   assign status_nxt = coreEvt.halted      ? rtp_pkg::PST_HALTED    :
                       coreEvt.stopped     ? rtp_pkg::PST_STOPPED   :
                       coreEvt.emulator    ? rtp_pkg::PST_EMULATOR  :
                       coreEvt.exception   ? rtp_pkg::PST_EXCEPTION :
                       coreEvt.branchTaken ? rtp_pkg::PST_BRANCH    :
                       (coreEvt.marker | writeTraceValid) ? rtp_pkg::PST_MARKER :
                       coreEvt.excReturn   ? rtp_pkg::PST_EXC_RET   :
                       coreEvt.userEntry   ? rtp_pkg::PST_USER      :
                       coreEvt.instrBegin  ? rtp_pkg::PST_BEGIN     :
                       announce            ? announceCode           :
                       rtp_pkg::PST_CONTINUE;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         status_r <= rtp_pkg::PST_CONTINUE;
         stall_r  <= 1'b0;
      end else begin
         status_r <= status_nxt;
         stall_r  <= ~fifoReady;
      end
   end

   assign core_status_nibble = status_r;
   assign coreStall          = stall_r;

endmodule

/* File: test/rtp_trace_capture.sv */
// Model of the external analyser collecting trace words
module rtp_trace_capture (
   input wire logic        clk_sys,
   input wire logic [3:0]  core_status_nibble,
   input wire logic [3:0]  trace_data_nibble,
   output logic [31:0]     capWord,
   output int              capCount
);
   timeunit 1ns;
   timeprecision 1ps;
   int          left     = 0;
   int          pos      = 0;
   int          count    = 0;
   logic [31:0] partial  = 32'h0;
   logic [31:0] lastWord = 32'h0;
   // A finished word is kept apart so a back to back start cannot clear it
   assign capWord  = lastWord;
   assign capCount = count;
   always @(posedge clk_sys) begin
      if (left != 0) begin
         partial[pos*4 +: 4] = trace_data_nibble;
         pos++;
         left--;
         if (left == 0) begin
            lastWord = partial;
            count++;
         end
      end
      if (core_status_nibble[3:2] == 2'h2) begin
         left    = 2 * (core_status_nibble[1:0] + 1);
         pos     = 0;
         partial = 32'h0;
      end
   end
endmodule

/* File: test/rtp_trace_port_checker.sv */
// Assertions on the trace port top
module rtp_trace_port_checker (
   input wire logic               clk_sys,
   input wire logic               reset,
   input rtp_pkg::rtp_core_evt_t  coreEvt,
   input wire logic               branchVariant,
   input wire logic [31:0]        branchTarget,
   input wire logic [1:0]         targetSize,
   input wire logic               operandValid,
   input wire logic [31:0]        operandData,
   input rtp_pkg::rtp_size_t      operandSize,
   input wire logic               writeTraceValid,
   input wire logic [31:0]        writeTraceData,
   input rtp_pkg::rtp_size_t      writeTraceSize,
   input wire logic               coreStall,
   input wire logic [3:0]         core_status_nibble,
   input wire logic [3:0]         trace_data_nibble
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire lvl = coreEvt.exception | coreEvt.emulator | coreEvt.stopped | coreEvt.halted;
   wire cap = operandValid | writeTraceValid | (coreEvt.branchTaken & branchVariant);
   wire hiBr = lvl | coreEvt.branchTaken;
   a_halt_code: assert property (coreEvt.halted |=> core_status_nibble == 4'hF)
      else $error("halt code missing");
   a_stop_code: assert property (coreEvt.stopped && !coreEvt.halted |=> core_status_nibble == 4'hE)
      else $error("stop code missing");
   a_exc_hold: assert property (coreEvt.exception && !(coreEvt.emulator || coreEvt.stopped || coreEvt.halted)
                                |=> core_status_nibble == 4'hC)
      else $error("exception code not held");
   a_branch_code: assert property (coreEvt.branchTaken && !lvl |=> core_status_nibble == 4'h5)
      else $error("branch code missing");
   a_marker_code: assert property ((coreEvt.marker || writeTraceValid) && !hiBr |=> core_status_nibble == 4'h4)
      else $error("marker code missing");
   a_begin_code: assert property (coreEvt == 9'h100 && !writeTraceValid |=> core_status_nibble == 4'h1)
      else $error("begin code missing");
   a_no_reserved: assert property (core_status_nibble != 4'h2 && core_status_nibble != 4'h6)
      else $error("reserved status code");
   a_stall_cause: assert property ($rose(coreStall) |-> $past(cap) || $past(cap, 2) || $past(cap, 3))
      else $error("stall without capture");
   a_stall_bound: assert property (coreStall |-> ##[1:40] !coreStall)
      else $error("stall never released");
   c_stall: cover property (coreStall);
   c_halt: cover property (core_status_nibble == 4'hF);
   c_four_byte: cover property (core_status_nibble == 4'hB);
endmodule
bind rtp_trace_port rtp_trace_port_checker u_chk (.clk_sys(clk_sys), .reset(reset), .coreEvt(coreEvt),
   .branchVariant(branchVariant), .branchTarget(branchTarget), .targetSize(targetSize),
   .operandValid(operandValid), .operandData(operandData), .operandSize(operandSize),
   .writeTraceValid(writeTraceValid), .writeTraceData(writeTraceData), .writeTraceSize(writeTraceSize),
   .coreStall(coreStall), .core_status_nibble(core_status_nibble), .trace_data_nibble(trace_data_nibble));

/* File: test/tb_realtime_trace_port.sv */
// Self-checking bench of the trace port
module tb_realtime_trace_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, reset, branchVariant, operandValid, writeTraceValid, coreStall;
   rtp_pkg::rtp_core_evt_t coreEvt;
   logic [31:0] branchTarget, operandData, writeTraceData, capWord;
   logic [1:0] targetSize;
   rtp_pkg::rtp_size_t operandSize, writeTraceSize;
   logic [3:0] core_status_nibble, trace_data_nibble;
   int errors = 0;
   int n_tests = 0;
   int capCount;
   rtp_trace_port u_dut (.clk_sys(clk_sys), .reset(reset), .coreEvt(coreEvt), .branchVariant(branchVariant),
      .branchTarget(branchTarget), .targetSize(targetSize), .operandValid(operandValid),
      .operandData(operandData), .operandSize(operandSize), .writeTraceValid(writeTraceValid),
      .writeTraceData(writeTraceData), .writeTraceSize(writeTraceSize), .coreStall(coreStall),
      .core_status_nibble(core_status_nibble), .trace_data_nibble(trace_data_nibble));
   rtp_trace_capture u_cap (.clk_sys(clk_sys), .core_status_nibble(core_status_nibble),
      .trace_data_nibble(trace_data_nibble), .capWord(capWord), .capCount(capCount));
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(int n = 1);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic end_of_test();
      if (errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wait_word(int target, logic [31:0] exp);
      for (int w = 0; w < 40 && capCount < target; w++) tick();
      check("word count", capCount, target);
      check("word", capWord, exp);
      tick();
      check("idle data", trace_data_nibble, 4'h0);
   endtask
   task automatic t_codes();
      logic [3:0] code [9] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'h4, 4'hC, 4'hD, 4'hE, 4'hF};
      for (int i = 0; i < 9; i++) begin
         coreEvt = 9'h100 >> i;
         repeat (i > 4 ? 3 : 1) begin
            tick();
            check("status", core_status_nibble, code[i]);
         end
         coreEvt = '0;
         tick();
         check("status next", core_status_nibble, 4'h0);
      end
   endtask
   task automatic t_operand();
      for (int s = 0; s < 4; s++) begin
         operandValid = 1'b1;
         operandData = 32'h7654_3210;
         operandSize = rtp_pkg::rtp_size_t'(s);
         tick();
         operandValid = 1'b0;
         tick();
         check("count code", core_status_nibble, 4'h8 + s);
         wait_word(capCount + 1, 32'h7654_3210 & (32'hFFFF_FFFF >> (8 * (3 - s))));
      end
   endtask
   task automatic t_branch();
      int sz;
      for (int t = 0; t < 4; t++) begin
         sz = (t == 0) ? 3 : t;
         targetSize = t[1:0];
         branchVariant = 1'b1;
         branchTarget = 32'h89AB_CDEF;
         coreEvt.branchTaken = 1'b1;
         tick();
         coreEvt = '0;
         check("branch code", core_status_nibble, 4'h5);
         tick();
         check("target count", core_status_nibble, 4'h8 + sz);
         wait_word(capCount + 1, 32'h89AB_CDEF & (32'hFFFF_FFFF >> (8 * (3 - sz))));
      end
   endtask
   task automatic t_write();
      writeTraceValid = 1'b1;
      writeTraceData = 32'hCAFE_0123;
      writeTraceSize = rtp_pkg::RTP_SZ_4;
      tick();
      writeTraceValid = 1'b0;
      check("write marker", core_status_nibble, 4'h4);
      tick();
      check("write count", core_status_nibble, 4'hB);
      wait_word(capCount + 1, 32'hCAFE_0123);
   endtask
   task automatic t_stall();
      int base = capCount;
      int seen = 0;
      operandSize = rtp_pkg::RTP_SZ_4;
      for (int i = 1; i < 4; i++) begin
         operandValid = 1'b1;
         operandData = 32'h1111_1111 * i;
         tick();
      end
      operandValid = 1'b0;
      for (int w = 0; w < 40 && !(seen == 1 && coreStall === 1'b0); w++) begin
         if (coreStall === 1'b1) seen = 1;
         tick();
      end
      check("stall seen", seen, 1);
      operandValid = 1'b1;
      operandData = 32'h4444_4444;
      tick();
      operandValid = 1'b0;
      wait_word(base + 4, 32'h4444_4444);
      check("stall free", coreStall, 1'b0);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      end_of_test();
   end
   initial begin
      {reset, branchVariant, operandValid, writeTraceValid, coreEvt} = {4'h8, 9'h0};
      {branchTarget, operandData, writeTraceData, targetSize} = '0;
      operandSize = rtp_pkg::RTP_SZ_1;
      writeTraceSize = rtp_pkg::RTP_SZ_1;
      tick(20);
      reset = 1'b0;
      tick();
      check("reset status", core_status_nibble, 4'h0);
      check("reset data", trace_data_nibble, 4'h0);
      t_codes();
      t_operand();
      t_branch();
      t_write();
      t_stall();
      end_of_test();
   end
endmodule
